// >>> eprom_write_sequencer.sv
// Slave-side sequencer for the data and status field write commands.
`timescale 1ns/10ps
`include "eprom_write_seq_regs.svh"

// Contract
// R1: Eight read slots return selected byte, LSB first.
// R2: Read-back equals AND of all programmed bytes.
// R3: Master reprograms byte when read-back shows stray ones; the testbench only counts the mismatch.
// R4: Address always advances after eight verify slots.
// R5: New address low byte loaded as CRC seed.
// R6: Later passes: data into seeded CRC, CRC returned.
// R7: First pass CRC covers command, addresses, data.
// R8: Master restarts sequence on CRC mismatch; the testbench pass task issues a bus reset, then still pulses and reads back.
// R9: Master applies 480 us programming pulse; the master model holds it for 200 cycles.
// R10: Device programs whenever pulse arrives, no CRC judgement.
// R11: Bus reset aborts sequence to idle.
// R12: Status write: addresses, one byte, CRC over four.
// R13: Programming clears only bits supplied as zero.
// R14: Unprogrammed first seven status bytes read ones.
// R15: Eighth status byte fixed at zero.
// R16: Every slot timed from master falling edge.
// R17: Device only pulls line low, never high.
// R18: Line idles high; long low means reset.
// R19: CRC is 8-bit, polynomial x8+x5+x4+1.
// R20: Data field write uses code 0fh, 1024 bits.
// R21: All bytes move least significant bit first.
module eprom_write_sequencer
  import eprom_write_seq_pkg::*;
#(
  parameter int RESET_LOW_CYC = `EWS_RESET_LOW_US * `EWS_CLK_MHZ,
  parameter int SLOT_MID_CYC  = `EWS_SLOT_MID_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Command layer hand-off, same clock domain
  input  wire logic rom_done,
  // Shared bus line, open drain
  input  wire logic dq_in,
  output logic      dq_out,
  output logic      dq_oe_n,
  // Programming voltage detector
  input  wire logic prog_in
);

  localparam logic [11:0] SLOT_MID = 12'(SLOT_MID_CYC - 1);
  localparam logic [15:0] RST_LAST = 16'(RESET_LOW_CYC - 1);

  seq_state_t  state_reg;
  logic        dq_s1, dq_s2, dq_s3;
  logic        pp_s1, pp_s2, pp_s3;
  logic        fall, prog_end, bus_reset;
  logic [15:0] low_cnt_reg;
  logic        slot_busy_reg;
  logic [11:0] slot_cnt_reg;
  logic        slot_mid;
  logic        rx_mode, tx_mode;
  logic [7:0]  rx_sh_reg;
  logic [2:0]  rx_cnt_reg;
  logic        rx_full_reg;
  logic        fifo_in_ready, fifo_out_valid, take;
  logic [7:0]  fifo_out_data;
  logic        field_status_reg;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic [7:0]  crc_reg;
  logic [7:0]  data_reg;
  logic [7:0]  tx_sh_reg;
  logic [3:0]  tx_cnt_reg;
  logic        tx_done;
  logic [7:0]  cur_byte, prog_val;
  logic [7:0]  data_mem [`EWS_DATA_BYTES];
  logic [7:0]  status_mem [`EWS_STATUS_BYTES];
  logic        dq_oe_n_reg;

  // Reflected LSB-first CRC step over one whole byte.
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ `EWS_CRC_POLY_REV) : (r >> 1); // R19 R21
    end
    return r;
  endfunction

  // Both pins come from outside the clock domain.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      dq_s1 <= 1'b1;
      dq_s2 <= 1'b1;
      dq_s3 <= 1'b1;
      pp_s1 <= 1'b0;
      pp_s2 <= 1'b0;
      pp_s3 <= 1'b0;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      pp_s1 <= prog_in;
      pp_s2 <= pp_s1;
      pp_s3 <= pp_s2;
    end
  end

  assign fall     = dq_s3 && !dq_s2; // R16
  assign prog_end = pp_s3 && !pp_s2; // R9
  assign bus_reset = !dq_s2 && (low_cnt_reg == RST_LAST); // R18

  // A line held low this long is a reset, not a slot.
  always_ff @(posedge clock) begin
    if (!nrst || dq_s2) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != 16'hffff) begin
      low_cnt_reg <= 16'(low_cnt_reg + 16'h1);
    end
  end

  // Slot timer: sampling and release both happen mid-slot.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      slot_busy_reg <= 1'b0;
      slot_cnt_reg  <= '0;
    end else if (fall) begin
      slot_busy_reg <= 1'b1; // R16
      slot_cnt_reg  <= '0;
    end else if (slot_mid) begin
      slot_busy_reg <= 1'b0;
    end else if (slot_busy_reg) begin
      slot_cnt_reg <= 12'(slot_cnt_reg + 12'h1);
    end
  end

  assign slot_mid = slot_busy_reg && (slot_cnt_reg == SLOT_MID);
  assign rx_mode  = (state_reg == ST_CMD) || (state_reg == ST_ADDR_LO) ||
                    (state_reg == ST_ADDR_HI) || (state_reg == ST_DATA);
  assign tx_mode  = (state_reg == ST_CRC_OUT) || (state_reg == ST_VERIFY);
  assign tx_done  = tx_mode && slot_mid && (tx_cnt_reg == 4'h7);

  // Byte assembler; a full FIFO holds the byte and further bits are dropped.
  always_ff @(posedge clock) begin
    if (!nrst || bus_reset) begin
      rx_sh_reg   <= '0;
      rx_cnt_reg  <= '0;
      rx_full_reg <= 1'b0;
    end else begin
      if (rx_full_reg && fifo_in_ready) begin
        rx_full_reg <= 1'b0;
      end else if (rx_mode && slot_mid && !rx_full_reg) begin
        rx_sh_reg  <= {dq_s2, rx_sh_reg[7:1]}; // R21
        rx_cnt_reg <= 3'(rx_cnt_reg + 3'h1);
        if (rx_cnt_reg == 3'h7) begin
          rx_full_reg <= 1'b1;
        end
      end
    end
  end

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`EWS_FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .flush     (bus_reset),
    .in_valid  (rx_full_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_sh_reg),
    .out_valid (fifo_out_valid),
    .out_ready (rx_mode),
    .out_data  (fifo_out_data)
  );

  assign take      = fifo_out_valid && rx_mode;
  assign addr_next = 16'(addr_reg + 16'h1);
  assign cur_byte  = field_status_reg ? status_mem[addr_reg[2:0]]
                                      : data_mem[addr_reg[6:0]];
  assign prog_val  = cur_byte & data_reg; // R13

  // Command sequence, address counter, CRC and transmit shifter.
  always_ff @(posedge clock) begin
    if (!nrst || bus_reset) begin
      state_reg        <= ST_IDLE; // R11
      field_status_reg <= 1'b0;
      addr_reg         <= '0;
      crc_reg          <= '0;
      data_reg         <= '0;
      tx_sh_reg        <= '0;
      tx_cnt_reg       <= '0;
    end else begin
      if (tx_mode && slot_mid) begin
        tx_sh_reg  <= {1'b1, tx_sh_reg[7:1]}; // R21
        tx_cnt_reg <= 4'(tx_cnt_reg + 4'h1);
      end
      case (state_reg)
        ST_IDLE: begin
          if (rom_done) begin
            state_reg <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (take) begin
            crc_reg <= crc8(8'h00, fifo_out_data); // R7
            if (fifo_out_data == `EWS_CMD_DATA_WR) begin
              field_status_reg <= 1'b0; // R20
              state_reg        <= ST_ADDR_LO;
            end else if (fifo_out_data == `EWS_CMD_STATUS_WR) begin
              field_status_reg <= 1'b1; // R12
              state_reg        <= ST_ADDR_LO;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_LO: begin
          if (take) begin
            addr_reg[7:0] <= fifo_out_data;
            crc_reg       <= crc8(crc_reg, fifo_out_data); // R7 R12
            state_reg     <= ST_ADDR_HI;
          end
        end
        ST_ADDR_HI: begin
          if (take) begin
            addr_reg[15:8] <= fifo_out_data;
            crc_reg        <= crc8(crc_reg, fifo_out_data); // R7 R12
            state_reg      <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (take) begin
            data_reg   <= fifo_out_data;
            crc_reg    <= crc8(crc_reg, fifo_out_data); // R6 R7
            tx_sh_reg  <= crc8(crc_reg, fifo_out_data); // R6
            tx_cnt_reg <= '0;
            state_reg  <= ST_CRC_OUT;
          end
        end
        ST_CRC_OUT: begin
          if (tx_done) begin
            state_reg <= ST_WAIT_PROG;
          end
        end
        ST_WAIT_PROG: begin
          // The device cannot tell a good CRC from a bad one here.
          if (prog_end) begin
            tx_sh_reg  <= prog_val; // R1 R2 R10
            tx_cnt_reg <= '0;
            state_reg  <= ST_VERIFY;
          end
        end
        ST_VERIFY: begin
          if (tx_done) begin
            addr_reg  <= addr_next; // R4
            crc_reg   <= addr_next[7:0]; // R5
            state_reg <= ST_DATA;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Power-up image of a blank part; the top status byte is fixed.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < `EWS_DATA_BYTES; i++) begin
        data_mem[i] <= `EWS_BLANK_BYTE;
      end
      for (int i = 0; i < `EWS_STATUS_BYTES - 1; i++) begin
        status_mem[i] <= `EWS_BLANK_BYTE; // R14
      end
      status_mem[`EWS_STATUS_BYTES-1] <= `EWS_STATUS_FIXED; // R15
    end else if (state_reg == ST_WAIT_PROG && prog_end && !bus_reset) begin
      if (field_status_reg) begin
        status_mem[addr_reg[2:0]] <= prog_val; // R13
      end else begin
        data_mem[addr_reg[6:0]] <= prog_val; // R13
      end
    end
  end

  // Pull low only for a zero bit of a read slot, released mid-slot.
  always_ff @(posedge clock) begin
    if (!nrst || bus_reset) begin
      dq_oe_n_reg <= 1'b1;
    end else if (fall && tx_mode && !tx_sh_reg[0]) begin
      dq_oe_n_reg <= 1'b0; // R17
    end else if (slot_mid || !tx_mode) begin
      dq_oe_n_reg <= 1'b1;
    end
  end

  assign dq_oe_n = dq_oe_n_reg;
  assign dq_out  = 1'b0;

  a_drive_only_tx: assert property (@(posedge clock) disable iff (!nrst)
    !dq_oe_n |-> tx_mode) // R17
    else $error("Line pulled low outside a read slot.");

  a_reset_to_idle: assert property (@(posedge clock) disable iff (!nrst)
    bus_reset |=> state_reg == ST_IDLE) // R11
    else $error("Bus reset did not abort the sequence.");

  a_verify_and: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ST_WAIT_PROG && prog_end && !bus_reset)
    |=> tx_sh_reg == ($past(cur_byte) & $past(data_reg))) // R2
    else $error("Verify byte is not the AND of old and new data.");

  a_prog_any_pulse: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ST_WAIT_PROG && prog_end && !bus_reset)
    |=> state_reg == ST_VERIFY) // R10
    else $error("Programming pulse not acted on.");

  a_addr_advance: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ST_VERIFY && tx_done && !bus_reset)
    |=> addr_reg == 16'($past(addr_reg) + 16'h1) && state_reg == ST_DATA) // R4
    else $error("Address did not advance after verify.");

  a_crc_seed: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ST_VERIFY && tx_done && !bus_reset)
    |=> crc_reg == 8'($past(addr_reg[7:0]) + 8'h1)) // R5
    else $error("CRC not seeded with new address low byte.");

  a_crc_return: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == ST_DATA && take && !bus_reset)
    |=> tx_sh_reg == crc_reg && state_reg == ST_CRC_OUT) // R6
    else $error("Returned CRC differs from the running CRC.");

  a_status_fixed: assert property (@(posedge clock) disable iff (!nrst)
    status_mem[`EWS_STATUS_BYTES-1] == `EWS_STATUS_FIXED) // R15
    else $error("Fixed status byte changed.");

  a_slot_release: assert property (@(posedge clock) disable iff (!nrst)
    (!dq_oe_n && slot_mid) |=> dq_oe_n) // R16
    else $error("Line not released at mid-slot.");

endmodule

// >>> eprom_write_seq_regs.svh
// Timing counts and protocol constants of the write sequencer.
`ifndef EPROM_WRITE_SEQ_REGS_SVH
`define EPROM_WRITE_SEQ_REGS_SVH

`define EWS_CLK_MHZ       100
`define EWS_SLOT_MID_US   30
`define EWS_SLOT_MID_CYC  (`EWS_SLOT_MID_US * `EWS_CLK_MHZ)
`define EWS_RESET_LOW_US  120
`define EWS_CMD_DATA_WR   8'h0f
`define EWS_CMD_STATUS_WR 8'h55
`define EWS_CRC_POLY_REV  8'h8c
`define EWS_BLANK_BYTE    8'hff
`define EWS_STATUS_FIXED  8'h00
`define EWS_DATA_BYTES    128
`define EWS_STATUS_BYTES  8
`define EWS_FIFO_DEPTH    8

`endif

// >>> eprom_write_seq_pkg.sv
// Types shared by the write sequencer files.
package eprom_write_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_CMD       = 3'b001,
    ST_ADDR_LO   = 3'b011,
    ST_ADDR_HI   = 3'b010,
    ST_DATA      = 3'b110,
    ST_CRC_OUT   = 3'b111,
    ST_WAIT_PROG = 3'b101,
    ST_VERIFY    = 3'b100
  } seq_state_t;

endpackage

// >>> byte_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             flush,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr_reg + 1'b1);
      end
      if (push && !pop) begin
        count_reg <= (AW+1)'(count_reg + 1'b1);
      end else if (pop && !push) begin
        count_reg <= (AW+1)'(count_reg - 1'b1);
      end
    end
  end

endmodule

// >>> bus_master_model.sv
// Behavioural bus master that times every slot on the shared line.
`timescale 1ns/10ps
module bus_master_model #(
  parameter int SLOT_CYC = 210,
  parameter int PROG_CYC = 200
) (
  // Clock
  input  wire logic clock,
  // Shared line and programming supply
  input  wire logic dq_line,
  output logic      pull_low,
  output logic      prog_hi
);
  initial begin
    pull_low = 1'b0;
    prog_hi  = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Slot figures assume a mid-slot point of 150 cycles, a reset of 300.
  // A zero stays low past the mid-slot sample but short of a bus reset.
  task automatic write_bit(input logic b);
    @(negedge clock);
    pull_low = 1'b1;
    idle(b ? 10 : 180);
    pull_low = 1'b0;
    idle(SLOT_CYC - (b ? 10 : 180));
  endtask

  task automatic read_bit(output logic b);
    @(negedge clock);
    pull_low = 1'b1;
    idle(5);
    pull_low = 1'b0;
    idle(75);
    b = dq_line;
    idle(SLOT_CYC - 80);
  endtask

  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) write_bit(v[i]);
  endtask

  task automatic read_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) read_bit(v[i]);
  endtask

  task automatic bus_reset;
    @(negedge clock);
    pull_low = 1'b1;
    idle(360);
    pull_low = 1'b0;
    idle(200);
  endtask

  // The pulse is far shorter than on the real bus to keep the run short.
  task automatic prog_pulse;
    @(negedge clock);
    prog_hi = 1'b1;
    idle(PROG_CYC);
    prog_hi = 1'b0;
    idle(20);
  endtask
endmodule

// >>> tb_eprom_write_sequencer.sv
// Self-checking testbench of the write sequencer.
`timescale 1ns/10ps
`include "eprom_write_seq_regs.svh"
module tb_eprom_write_sequencer;
  logic clock;
  logic nrst;
  logic rom_done;
  logic dq_out;
  logic dq_oe_n;
  logic pull_low;
  logic prog_hi;
  wire  dq_line;
  int   miscompares;
  int   cmp_count;
  logic [7:0] rd;

  // The pull-up wins unless some party pulls the line low.
  assign dq_line = ~(pull_low | (~dq_oe_n & ~dq_out));

  eprom_write_sequencer #(
    .RESET_LOW_CYC(300),
    .SLOT_MID_CYC (150)
  ) i_eprom_write_sequencer (
    .clock   (clock),
    .nrst    (nrst),
    .rom_done(rom_done),
    .dq_in   (dq_line),
    .dq_out  (dq_out),
    .dq_oe_n (dq_oe_n),
    .prog_in (prog_hi)
  );

  bus_master_model i_bus_master_model (
    .clock   (clock),
    .dq_line (dq_line),
    .pull_low(pull_low),
    .prog_hi (prog_hi)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) r = (r[0] ^ b[i]) ? ((r >> 1) ^ 8'h8c) : (r >> 1);
    return r;
  endfunction

  function automatic logic [7:0] crc3(input logic [7:0] a, b, c);
    return crc_step(crc_step(crc_step(8'h00, a), b), c);
  endfunction

  task automatic open_cmd(input logic [7:0] cmd, lo, hi);
    @(negedge clock);
    rom_done = 1'b1;
    @(negedge clock);
    rom_done = 1'b0;
    i_bus_master_model.write_byte(cmd);
    i_bus_master_model.write_byte(lo);
    i_bus_master_model.write_byte(hi);
  endtask

  // One data byte, its CRC, the pulse and the read-back.
  task automatic pass(input logic [7:0] seed, data, exp_verify);
    i_bus_master_model.write_byte(data);
    i_bus_master_model.read_byte(rd);
    check_byte(rd, crc_step(seed, data));
    if (rd !== crc_step(seed, data)) begin
      i_bus_master_model.bus_reset();
    end
    i_bus_master_model.prog_pulse();
    i_bus_master_model.read_byte(rd);
    check_byte(rd, exp_verify);
  endtask

  task automatic t_data_write;
    open_cmd(`EWS_CMD_DATA_WR, 8'h05, 8'h00);
    pass(crc3(`EWS_CMD_DATA_WR, 8'h05, 8'h00), 8'ha5, 8'ha5);
    pass(8'h06, 8'h3c, 8'h3c);
  endtask

  task automatic t_reprogram;
    i_bus_master_model.bus_reset();
    open_cmd(`EWS_CMD_DATA_WR, 8'h05, 8'h00);
    pass(crc3(`EWS_CMD_DATA_WR, 8'h05, 8'h00), 8'h0f, 8'h05);
    pass(8'h06, 8'hf0, 8'h30);
  endtask

  task automatic t_status_write;
    i_bus_master_model.bus_reset();
    open_cmd(`EWS_CMD_STATUS_WR, 8'h06, 8'h00);
    pass(crc3(`EWS_CMD_STATUS_WR, 8'h06, 8'h00), 8'h12, 8'h12);
    pass(8'h07, 8'hff, 8'h00);
  endtask

  // A reset between CRC read-out and pulse must leave the byte blank.
  task automatic t_abort;
    i_bus_master_model.bus_reset();
    open_cmd(`EWS_CMD_DATA_WR, 8'h10, 8'h00);
    i_bus_master_model.write_byte(8'h00);
    i_bus_master_model.read_byte(rd);
    i_bus_master_model.bus_reset();
    i_bus_master_model.read_byte(rd);
    check_byte(rd, 8'hff);
    open_cmd(`EWS_CMD_DATA_WR, 8'h10, 8'h00);
    pass(crc3(`EWS_CMD_DATA_WR, 8'h10, 8'h00), 8'hff, 8'hff);
    check_byte({7'h00, dq_out}, 8'h00);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    miscompares = 0;
    cmp_count = 0;
    nrst = 1'b0;
    rom_done = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    t_data_write();
    t_reprogram();
    t_status_write();
    t_abort();
    tally_and_finish();
  end

  // Some 312 slots of 211 cycles are expected; the rest is margin.
  initial begin
    repeat (95000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
endmodule
